// ==== verilog/warn_mgr_pkg.sv ====
package warn_mgr_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OUT_SEL = 8'h04;
  localparam logic [7:0] OFS_OSC_LEVEL = 8'h08;
  localparam logic [7:0] OFS_WARN_MASK = 8'h0C;
  localparam logic [7:0] OFS_MAINS_TIME = 8'h10;
  localparam logic [7:0] OFS_SCALE_TYPE = 8'h14;
  localparam logic [7:0] OFS_SCALE_NUM = 8'h18;
  localparam logic [7:0] OFS_SCALE_DEN = 8'h1C;
  localparam logic [7:0] OFS_RSVD_PARAM = 8'h20;
  localparam logic [7:0] OFS_WARN_STAT = 8'h24;
  localparam logic [7:0] OFS_FAULT = 8'h28;
  localparam logic [7:0] OFS_NET_STAT = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SEL_B_POS = 8;
  localparam int FLT_SUB_POS = 8;
  localparam int FLT_ACT_POS = 16;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_WARN_BIT = 1;
  localparam logic [15:0] RSVD_PARAM_RST = 16'h0000;
  localparam logic [15:0] SCALE_RST = 16'h0001;
  localparam logic [10:0] MAINS_TIME_RST = 11'h000;
  // ****************************************
  // warning selector values and warning count
  // ****************************************
  localparam logic [3:0] SEL_ALL = 4'h0;
  localparam logic [3:0] SEL_OVERLOAD = 4'h1;
  localparam logic [3:0] SEL_BATTERY = 4'h3;
  localparam logic [3:0] SEL_FAN = 4'h4;
  localparam logic [3:0] SEL_OSC = 4'h7;
  localparam logic [3:0] SEL_MAINS = 4'hE;
  localparam int NWARN = 15;
  // ****************************************
  // fault codes
  // ****************************************
  localparam logic [7:0] FLT_SETUP = 8'd93;
  localparam logic [7:0] SUB_RATIO = 8'd2;
  localparam logic [7:0] SUB_SCALE_TYPE = 8'd3;
  localparam logic [7:0] SUB_RSVD = 8'd7;
  localparam logic [7:0] FLT_MOTOR = 8'd95;
  localparam logic [7:0] SUB_MOTOR_MAX = 8'd4;
  localparam logic [7:0] FLT_NET_INIT = 8'd98;
  localparam logic [7:0] SUB_NET_INIT = 8'd4;
  localparam logic [7:0] FLT_OTHER = 8'd99;
  localparam logic [7:0] FLT_NONE = 8'd0;
  // ****************************************
  // thresholds and timing, in ms ticks
  // ****************************************
  localparam logic [23:0] RATIO_MIN_DIV = 24'd40;
  localparam logic [23:0] RATIO_MAX_MUL = 24'd160;
  localparam logic [7:0] OVERLOAD_PCT = 8'd85;
  localparam int HOLD_S = 1;
  localparam int TICK_PER_S = 1000;
  localparam logic [10:0] HOLD_TICKS = 11'(HOLD_S * TICK_PER_S);
  localparam logic [10:0] FAN_TICKS = 11'(HOLD_S * TICK_PER_S);
  localparam logic [10:0] MAINS_MIN_MS = 11'd10;
  localparam logic [10:0] MAINS_OFF_MS = 11'd2000;
  localparam logic [10:0] CNT_MAX = 11'h7FF;
endpackage : warn_mgr_pkg

// ==== verilog/warn_mgr.sv ====
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// (R1) setup fault when scale ratio outside 1/40..160
// (R2) fault 93/3 on scale type mismatch
// (R3) setup fault sub 7 on bad reserved parameter
// (R4) fault 95 sub 0..4 on motor mismatch
// (R5) fault 98/4 when network init fails
// (R6) other-error fault on self-diagnosis failure
// (R7) non-latch: auto-clear one second after cause
// (R8) latch mode: hold until alarm clear
// (R9) battery warning follows encoder latch
// (R10) alarm clear input forces warnings cleared
// (R11) two selectors, zero means OR of all
// (R12) oscillation above level, zero level disables
// (R13) mask bit one suppresses that warning
// (R14) mains-off after detect time, 0-9/2000 disable
// (R15) mains-loss flag set when mains off detected
// (R16) warning re-raised after clear if cause persists
// (R17) overload at 85 percent, selector 1, bit 7
// (R18) fan stopped one second, selector 4, bit 6
// (R19) ms-tick timers restart when condition changes
module warn_mgr
  import warn_mgr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MS_TICK,
  input wire logic ALARM_CLEAR_IN,
  input wire logic MAINS_LOSS_IN,
  input wire logic FAN_STOPPED_IN,
  input wire logic BATT_LATCH_IN,
  input wire logic [7:0] LOAD_PCT,
  input wire logic [10:0] TORQUE_VIB,
  input wire logic [1:0] SCALE_COMM_TYPE,
  input wire logic MOTOR_MISMATCH,
  input wire logic [2:0] MOTOR_SUB,
  input wire logic NET_INIT_FAIL,
  input wire logic SELF_DIAG_FAIL,
  input wire logic [14:0] OTHER_CAUSE,
  output logic WARNING_OUTPUT_A,
  output logic WARNING_OUTPUT_B,
  output logic IRQ
);
  // ****************************************
  // helpers
  // ****************************************
  // mask bit position for each selector value, -1 when none
  function automatic int mask_pos(input int k);
    case (k)
      1: mask_pos = 7;
      2: mask_pos = 5;
      3: mask_pos = 0;
      4: mask_pos = 6;
      5: mask_pos = 4;
      6: mask_pos = 3;
      7: mask_pos = 13;
      8: mask_pos = 2;
      9: mask_pos = 8;
      10: mask_pos = 14;
      14: mask_pos = 12;
      default: mask_pos = -1;
    endcase
  endfunction : mask_pos

  // pick one warning by selector; unknown values give zero
  function automatic logic pick(input logic [3:0] sel, input logic [14:0] w);
    if (sel == SEL_ALL) begin
      pick = |w;
    end else if (mask_pos(int'(sel)) < 0) begin
      pick = 1'b0;
    end else begin
      pick = w[sel];
    end
  endfunction : pick

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [3:0] sync1_q, sync2_q;
  logic clr_s, mains_s, fan_s, batt_s;
  // pins, two stages before use
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (CLK_EN) begin
      sync1_q <= {BATT_LATCH_IN, FAN_STOPPED_IN, MAINS_LOSS_IN, ALARM_CLEAR_IN};
      sync2_q <= sync1_q;
    end
  end
  assign {batt_s, fan_s, mains_s, clr_s} = sync2_q;

  // ****************************************
  // settings registers
  // ****************************************
  logic latch_q;
  logic [3:0] sel_a_q, sel_b_q;
  logic [10:0] osc_level_q, mains_time_q;
  logic [15:0] mask_q, num_q, den_q, rsvd_q;
  logic [1:0] scale_type_q, irq_mask_q, irq_st_q, irq_ev;
  logic wr_en, rd_setup;
  logic [31:0] rdata_d;
  logic addr_ok;
  assign wr_en = CLK_EN && PSEL && PENABLE && PWRITE;
  assign rd_setup = CLK_EN && PSEL && !PENABLE && !PWRITE;

  // software writes, one word per register
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      latch_q <= 1'b0;
      sel_a_q <= SEL_ALL;
      sel_b_q <= SEL_ALL;
      osc_level_q <= 11'h000;
      mask_q <= 16'h0000;
      mains_time_q <= MAINS_TIME_RST;
      scale_type_q <= 2'h0;
      num_q <= SCALE_RST;
      den_q <= SCALE_RST;
      rsvd_q <= RSVD_PARAM_RST;
      irq_mask_q <= 2'h0;
    end else if (wr_en) begin
      case (PADDR)
        OFS_CTRL: latch_q <= PWDATA[0];
        OFS_OUT_SEL: begin
          sel_a_q <= PWDATA[3:0];
          sel_b_q <= PWDATA[SEL_B_POS +: 4];
        end
        OFS_OSC_LEVEL: osc_level_q <= PWDATA[10:0];
        OFS_WARN_MASK: mask_q <= PWDATA[15:0];
        OFS_MAINS_TIME: mains_time_q <= PWDATA[10:0];
        OFS_SCALE_TYPE: scale_type_q <= PWDATA[1:0];
        OFS_SCALE_NUM: num_q <= PWDATA[15:0];
        OFS_SCALE_DEN: den_q <= PWDATA[15:0];
        OFS_RSVD_PARAM: rsvd_q <= PWDATA[15:0];
        OFS_IRQ_MASK: irq_mask_q <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // ms-tick timers
  // ****************************************
  logic [10:0] fan_cnt_q, mains_cnt_q;
  logic tick, mains_en, mains_det;
  assign tick = CLK_EN && MS_TICK;
  // counters restart whenever the watched level drops
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fan_cnt_q <= 11'h000;
      mains_cnt_q <= 11'h000;
    end else if (CLK_EN) begin
      if (!fan_s) begin
        fan_cnt_q <= 11'h000; // R19
      end else if (tick && fan_cnt_q != FAN_TICKS) begin
        fan_cnt_q <= fan_cnt_q + 11'h001;
      end
      if (!mains_s) begin
        mains_cnt_q <= 11'h000; // R19
      end else if (tick && mains_cnt_q != CNT_MAX) begin
        mains_cnt_q <= mains_cnt_q + 11'h001;
      end
    end
  end
  assign mains_en = mains_time_q >= MAINS_MIN_MS && mains_time_q < MAINS_OFF_MS; // R14
  assign mains_det = mains_en && mains_cnt_q > mains_time_q; // R14

  // ****************************************
  // warning causes
  // ****************************************
  logic [14:0] raw, cause;
  // detectors; other slots come from outside monitors
  always_comb begin
    raw = OTHER_CAUSE;
    raw[0] = 1'b0;
    raw[SEL_OVERLOAD] = LOAD_PCT >= OVERLOAD_PCT; // R17
    raw[SEL_BATTERY] = batt_s;
    raw[SEL_FAN] = fan_cnt_q == FAN_TICKS; // R18
    raw[SEL_OSC] = osc_level_q != 11'h000 && TORQUE_VIB > osc_level_q; // R12
    raw[SEL_MAINS] = mains_det;
    for (int k = 0; k < NWARN; k++) begin
      if (mask_pos(k) < 0) begin
        cause[k] = 1'b0;
      end else begin
        cause[k] = raw[k] && !mask_q[mask_pos(k)]; // R13
      end
    end
  end

  // ****************************************
  // warning state and auto-clear
  // ****************************************
  logic [14:0] warn_q, warn_d, hold_done;
  logic [10:0] hold_q [NWARN];
  always_comb begin
    for (int k = 0; k < NWARN; k++) begin
      hold_done[k] = tick && hold_q[k] == HOLD_TICKS - 11'h001; // R7
      if (clr_s) begin
        warn_d[k] = 1'b0; // R10
      end else if (k == int'(SEL_BATTERY)) begin
        warn_d[k] = cause[k]; // R9
      end else if (cause[k]) begin
        warn_d[k] = 1'b1; // R16
      end else if (latch_q) begin
        warn_d[k] = warn_q[k]; // R8
      end else begin
        warn_d[k] = warn_q[k] && !hold_done[k]; // R7
      end
    end
  end

  // one hold timer per warning, restarted while cause stands
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      warn_q <= 15'h0000;
      for (int k = 0; k < NWARN; k++) begin
        hold_q[k] <= 11'h000;
      end
    end else if (CLK_EN) begin
      warn_q <= warn_d;
      for (int k = 0; k < NWARN; k++) begin
        if (cause[k] || !warn_q[k]) begin
          hold_q[k] <= 11'h000; // R19
        end else if (tick) begin
          hold_q[k] <= hold_q[k] + 11'h001;
        end
      end
    end
  end

  // selected outputs, registered
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WARNING_OUTPUT_A <= 1'b0;
      WARNING_OUTPUT_B <= 1'b0;
    end else if (CLK_EN) begin
      WARNING_OUTPUT_A <= pick(sel_a_q, warn_q); // R11
      WARNING_OUTPUT_B <= pick(sel_b_q, warn_q); // R11
    end
  end

  // ****************************************
  // fault codes, highest priority first
  // ****************************************
  logic ratio_bad;
  logic [7:0] fmain_d, fsub_d, fmain_q, fsub_q;
  logic mains_flag_q;
  // ratio below 1/40 or above 160, zero divisor too
  assign ratio_bad = den_q == 16'h0000
    || 24'(num_q) * RATIO_MIN_DIV < 24'(den_q)
    || 24'(num_q) > 24'(den_q) * RATIO_MAX_MUL; // R1
  always_comb begin
    fmain_d = FLT_NONE;
    fsub_d = 8'h00;
    if (NET_INIT_FAIL) begin
      fmain_d = FLT_NET_INIT; // R5
      fsub_d = SUB_NET_INIT;
    end else if (MOTOR_MISMATCH) begin
      fmain_d = FLT_MOTOR; // R4
      fsub_d = (8'(MOTOR_SUB) > SUB_MOTOR_MAX) ? SUB_MOTOR_MAX : 8'(MOTOR_SUB);
    end else if (SCALE_COMM_TYPE != scale_type_q) begin
      fmain_d = FLT_SETUP; // R2
      fsub_d = SUB_SCALE_TYPE;
    end else if (ratio_bad) begin
      fmain_d = FLT_SETUP; // R1
      fsub_d = SUB_RATIO;
    end else if (rsvd_q != RSVD_PARAM_RST) begin
      fmain_d = FLT_SETUP; // R3
      fsub_d = SUB_RSVD;
    end else if (SELF_DIAG_FAIL) begin
      fmain_d = FLT_OTHER; // R6
    end
  end

  // fault code and mains-loss flag follow their causes
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fmain_q <= FLT_NONE;
      fsub_q <= 8'h00;
      mains_flag_q <= 1'b0;
    end else if (CLK_EN) begin
      fmain_q <= fmain_d;
      fsub_q <= fsub_d;
      mains_flag_q <= mains_det; // R15
    end
  end

  // ****************************************
  // interrupts and read path
  // ****************************************
  assign irq_ev[IRQ_FAULT_BIT] = fmain_d != FLT_NONE && fmain_q == FLT_NONE;
  assign irq_ev[IRQ_WARN_BIT] = |(warn_d & ~warn_q);
  // write-one-to-clear; a new event beats the clear
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_st_q <= 2'h0;
    end else if (CLK_EN) begin
      if (wr_en && PADDR == OFS_IRQ_STAT) begin
        irq_st_q <= (irq_st_q & ~PWDATA[1:0]) | irq_ev;
      end else begin
        irq_st_q <= irq_st_q | irq_ev;
      end
    end
  end
  // a one in the mask hides that source, as with the warning mask
  assign IRQ = |(irq_st_q & ~irq_mask_q);

  always_comb begin
    rdata_d = 32'h0000_0000;
    addr_ok = 1'b1;
    case (PADDR)
      OFS_CTRL: rdata_d[0] = latch_q;
      OFS_OUT_SEL: rdata_d = 32'({sel_b_q, 4'h0, sel_a_q});
      OFS_OSC_LEVEL: rdata_d = 32'(osc_level_q);
      OFS_WARN_MASK: rdata_d = 32'(mask_q);
      OFS_MAINS_TIME: rdata_d = 32'(mains_time_q);
      OFS_SCALE_TYPE: rdata_d = 32'(scale_type_q);
      OFS_SCALE_NUM: rdata_d = 32'(num_q);
      OFS_SCALE_DEN: rdata_d = 32'(den_q);
      OFS_RSVD_PARAM: rdata_d = 32'(rsvd_q);
      OFS_WARN_STAT: rdata_d = 32'(warn_q);
      OFS_FAULT: begin
        rdata_d[7:0] = fmain_q;
        rdata_d[FLT_SUB_POS +: 8] = fsub_q;
        rdata_d[FLT_ACT_POS] = fmain_q != FLT_NONE;
      end
      OFS_NET_STAT: rdata_d[0] = mains_flag_q;
      OFS_IRQ_STAT: rdata_d = 32'(irq_st_q);
      OFS_IRQ_MASK: rdata_d = 32'(irq_mask_q);
      default: addr_ok = 1'b0;
    endcase
  end

  // read data caught in setup, valid through access
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= rdata_d;
    end
  end
  // zero wait states; frozen clock holds the access
  assign PREADY = PSEL && PENABLE && CLK_EN;
  assign PSLVERR = PREADY && !addr_ok;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  AST_RATIO: assert property (CLK_EN && ratio_bad && !NET_INIT_FAIL && !MOTOR_MISMATCH // R1
    && SCALE_COMM_TYPE == scale_type_q |=> fmain_q == FLT_SETUP && fsub_q == SUB_RATIO)
    else $error("ratio fault missing");
  AST_SCALE_TYPE: assert property (CLK_EN && !NET_INIT_FAIL && !MOTOR_MISMATCH // R2
    && SCALE_COMM_TYPE != scale_type_q |=> fmain_q == FLT_SETUP && fsub_q == SUB_SCALE_TYPE)
    else $error("scale type fault missing");
  AST_MOTOR: assert property (CLK_EN && MOTOR_MISMATCH && !NET_INIT_FAIL // R4
    |=> fmain_q == FLT_MOTOR && fsub_q <= SUB_MOTOR_MAX)
    else $error("motor fault wrong");
  AST_NET: assert property (CLK_EN && NET_INIT_FAIL // R5
    |=> fmain_q == FLT_NET_INIT && fsub_q == SUB_NET_INIT)
    else $error("network init fault wrong");
  AST_OTHER: assert property (CLK_EN && SELF_DIAG_FAIL |=> fmain_q != FLT_NONE) // R6
    else $error("self diagnosis fault missing");
  AST_AUTOCLR: assert property ($fell(warn_q[SEL_OVERLOAD]) // R7
    |-> $past(clr_s) || (!$past(latch_q) && $past(hold_done[SEL_OVERLOAD])))
    else $error("warning dropped early");
  AST_LATCH: assert property (CLK_EN && latch_q && !clr_s && warn_q[SEL_FAN] // R8
    |=> warn_q[SEL_FAN])
    else $error("latched warning lost");
  AST_BATT: assert property (CLK_EN && !clr_s && batt_s && !mask_q[0] // R9
    |=> warn_q[SEL_BATTERY])
    else $error("battery warning missing");
  AST_CLEAR: assert property (CLK_EN && clr_s |=> warn_q == 15'h0000) // R10
    else $error("alarm clear ignored");
  AST_SEL_ALL: assert property (CLK_EN && sel_a_q == SEL_ALL // R11
    |=> WARNING_OUTPUT_A == |$past(warn_q))
    else $error("output a not ored");
  AST_OSC_OFF: assert property (osc_level_q == 11'h000 |-> !cause[SEL_OSC]) // R12
    else $error("oscillation check not disabled");
  AST_MASK: assert property (mask_q[7] |-> !cause[SEL_OVERLOAD]) // R13
    else $error("masked warning detected");
  AST_MAINS_OFF: assert property (mains_time_q < MAINS_MIN_MS // R14
    || mains_time_q == MAINS_OFF_MS |-> !mains_det)
    else $error("mains check not disabled");
  AST_FLAG: assert property (CLK_EN && mains_det |=> mains_flag_q) // R15
    else $error("mains loss flag not set");
  AST_REARM: assert property (CLK_EN && !clr_s && cause[SEL_OVERLOAD] // R16
    |=> warn_q[SEL_OVERLOAD])
    else $error("warning not raised again");
  AST_LOAD: assert property (LOAD_PCT >= OVERLOAD_PCT && !mask_q[7] // R17
    |-> cause[SEL_OVERLOAD])
    else $error("overload not detected");
  AST_FAN: assert property (CLK_EN && fan_s && fan_cnt_q == FAN_TICKS && !mask_q[6] // R18
    |-> cause[SEL_FAN])
    else $error("fan warning missing");
  AST_RESTART: assert property (CLK_EN && !mains_s |=> mains_cnt_q == 11'h000) // R19
    else $error("mains timer not restarted");

  COV_AUTOCLR: cover property (warn_q[SEL_OVERLOAD] ##1 !warn_q[SEL_OVERLOAD] && !clr_s);
  COV_MAINS: cover property (!mains_flag_q ##1 mains_flag_q);
  COV_CLEAR: cover property (clr_s && warn_q != 15'h0000);
  COV_IRQ: cover property (!IRQ ##1 IRQ);
endmodule : warn_mgr

// ==== test/host_side_model.sv ====
`timescale 1ns/100ps
// ****************************************
// host side: millisecond tick and clear pin
// ****************************************
module host_side_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr_req,
  output logic ms_tick,
  output logic alarm_clear
);
  logic [7:0] div_q;
  // short tick period keeps the one-second timers cheap to run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      ms_tick <= 1'b0;
    end else begin
      div_q <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
      ms_tick <= (div_q == 8'(TICK_DIV - 1));
    end
  end
  // clear pin follows the request one edge later, like a host output port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_clear <= 1'b0;
    end else begin
      alarm_clear <= clr_req;
    end
  end
endmodule : host_side_model

// ==== test/servo_warning_manager_tb.sv ====
`timescale 1ns/100ps
module servo_warning_manager_tb import warn_mgr_pkg::*;;
  // ****************************************
  // stimulus table and bench signals
  // ****************************************
  typedef struct packed {
    logic [7:0] ld;
    logic [10:0] vib;
    logic [10:0] osc;
    logic [15:0] msk;
    logic [14:0] oth;
    logic [3:0] sa;
    logic [3:0] sb;
    logic [31:0] st;
    logic a;
    logic b;
  } row_t;
  localparam int TDIV = 4;
  row_t rows [7] = '{
    '{8'h55, 11'h000, 11'h000, 16'h0000, 15'h0000, 4'h1, 4'h7, 32'h0000_0002, 1'b1, 1'b0},
    '{8'h54, 11'h1F4, 11'h1F3, 16'h0000, 15'h0000, 4'h7, 4'h0, 32'h0000_0080, 1'b1, 1'b1},
    '{8'h54, 11'h1F4, 11'h1F4, 16'h0000, 15'h0000, 4'h7, 4'h0, 32'h0000_0000, 1'b0, 1'b0},
    '{8'h00, 11'h3E8, 11'h000, 16'h0000, 15'h0000, 4'h0, 4'h7, 32'h0000_0000, 1'b0, 1'b0},
    '{8'h5A, 11'h000, 11'h000, 16'h0080, 15'h0000, 4'h1, 4'h0, 32'h0000_0000, 1'b0, 1'b0},
    '{8'h5A, 11'h258, 11'h064, 16'h2000, 15'h0000, 4'h0, 4'h7, 32'h0000_0002, 1'b1, 1'b0},
    '{8'h00, 11'h000, 11'h000, 16'h0000, 15'h0004, 4'h2, 4'hC, 32'h0000_0004, 1'b1, 1'b0}};
  logic clk, rst_n, clk_en, psel, penable, pwrite, mains, fan, batt, mot, net, diag, clr_req;
  logic pready, pslverr, tick, aclr, wa, wb, irq, wa_s, wb_s, irq_s, err_v;
  logic [7:0] paddr, load;
  logic [31:0] pwdata, prdata, rd_v;
  logic [10:0] vib;
  logic [1:0] stype;
  logic [2:0] msub;
  logic [14:0] oth;
  int error_cnt = 0;
  int samples_checked = 0;

  warn_mgr i_warn_mgr (.REF_CLK(clk), .RSTN(rst_n), .CLK_EN(clk_en), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MS_TICK(tick), .ALARM_CLEAR_IN(aclr),
    .MAINS_LOSS_IN(mains), .FAN_STOPPED_IN(fan), .BATT_LATCH_IN(batt), .LOAD_PCT(load),
    .TORQUE_VIB(vib), .SCALE_COMM_TYPE(stype), .MOTOR_MISMATCH(mot), .MOTOR_SUB(msub),
    .NET_INIT_FAIL(net), .SELF_DIAG_FAIL(diag), .OTHER_CAUSE(oth),
    .WARNING_OUTPUT_A(wa), .WARNING_OUTPUT_B(wb), .IRQ(irq));
  host_side_model #(.TICK_DIV(TDIV)) i_host_side_model (.clk(clk), .rst_n(rst_n),
    .clr_req(clr_req), .ms_tick(tick), .alarm_clear(aclr));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // pins sampled mid-cycle so checks never race the output flops
  always @(negedge clk) begin
    {wa_s, wb_s, irq_s} <= {wa, wb, irq};
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog expected done seen hang");
    stop_test();
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd_v = prdata;
    err_v = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 16) begin
      error_cnt++;
      stop_test();
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task clear_pulse();
    clr_req <= 1'b1;
    cyc(6);
    clr_req <= 1'b0;
    cyc(10);
  endtask : clear_pulse
  task fchk(input logic [31:0] e);
    cyc(2);
    rd(OFS_FAULT);
    chk("fault", rd_v, e);
  endtask : fchk
  function automatic logic [31:0] fexp(input logic [7:0] m, input logic [7:0] s);
    return {15'h0000, 1'b1, s, m};
  endfunction : fexp

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_n, psel, penable, pwrite, mains, fan, batt, mot, net, diag, clr_req} = '0;
    {paddr, pwdata, load, vib, stype, msub, oth} = '0;
    clk_en = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_SCALE_TYPE, 32'h0000_0000);
    // table rows, latch mode: clear then cause re-raises
    foreach (rows[i]) begin
      wr(OFS_OSC_LEVEL, 32'(rows[i].osc));
      wr(OFS_WARN_MASK, 32'(rows[i].msk));
      wr(OFS_OUT_SEL, {20'h0_0000, rows[i].sb, 4'h0, rows[i].sa});
      {load, vib, oth} <= {rows[i].ld, rows[i].vib, rows[i].oth};
      clear_pulse();
      rd(OFS_WARN_STAT);
      chk("warn_stat", rd_v, rows[i].st);
      chk("out_a", 32'(wa_s), 32'(rows[i].a));
      chk("out_b", 32'(wb_s), 32'(rows[i].b));
    end
    {load, vib, oth} <= '0;
    clear_pulse();
    // reset values and an unmapped place
    rd(OFS_SCALE_NUM);
    chk("scale_num", rd_v, 32'h0000_0001);
    rd(OFS_RSVD_PARAM);
    chk("rsvd", rd_v, 32'h0000_0000);
    rd(8'h3C);
    chk("slverr", 32'(err_v), 32'h0000_0001);
    // faults at both ratio limits, then in priority order
    wr(OFS_SCALE_NUM, 32'h0000_00A0);
    fchk(32'h0000_0000);
    wr(OFS_SCALE_NUM, 32'h0000_00A1);
    fchk(fexp(FLT_SETUP, SUB_RATIO));
    wr(OFS_SCALE_NUM, 32'h0000_0001);
    wr(OFS_SCALE_DEN, 32'h0000_0028);
    fchk(32'h0000_0000);
    wr(OFS_SCALE_DEN, 32'h0000_0029);
    fchk(fexp(FLT_SETUP, SUB_RATIO));
    wr(OFS_SCALE_DEN, 32'h0000_0001);
    wr(OFS_RSVD_PARAM, 32'h0000_0001);
    fchk(fexp(FLT_SETUP, SUB_RSVD));
    wr(OFS_RSVD_PARAM, 32'h0000_0000);
    wr(OFS_SCALE_TYPE, 32'h0000_0001);
    fchk(fexp(FLT_SETUP, SUB_SCALE_TYPE));
    wr(OFS_SCALE_TYPE, 32'h0000_0000);
    diag <= 1'b1;
    fchk(fexp(FLT_OTHER, 8'h00));
    {mot, msub} <= 4'hA;
    fchk(fexp(FLT_MOTOR, 8'h02));
    msub <= 3'h4;
    fchk(fexp(FLT_MOTOR, SUB_MOTOR_MAX));
    net <= 1'b1;
    fchk(fexp(FLT_NET_INIT, SUB_NET_INIT));
    {diag, mot, net} <= 3'h0;
    fchk(32'h0000_0000);
    // interrupt: raised, masked, cleared
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    rd(OFS_IRQ_STAT);
    chk("irq_stat", rd_v, 32'h0000_0003);
    chk("irq", 32'(irq_s), 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0003);
    cyc(2);
    chk("irq_masked", 32'(irq_s), 32'h0000_0000);
    wr(OFS_IRQ_STAT, 32'h0000_0003);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    rd(OFS_IRQ_STAT);
    chk("irq_stat", rd_v, 32'h0000_0000);
    chk("irq", 32'(irq_s), 32'h0000_0000);
    // latch mode holds past one second, clear pin drops it
    wr(OFS_OUT_SEL, 32'h0000_0001);
    load <= 8'h55;
    cyc(4);
    load <= 8'h00;
    cyc(1100 * TDIV);
    chk("latched", 32'(wa_s), 32'h0000_0001);
    clr_req <= 1'b1;
    cyc(6);
    chk("forced", 32'(wa_s), 32'h0000_0000);
    clr_req <= 1'b0;
    // non-latch: timer restarts when the cause returns
    wr(OFS_CTRL, 32'h0000_0000);
    load <= 8'h55;
    cyc(4);
    load <= 8'h00;
    cyc(600 * TDIV);
    load <= 8'h55;
    cyc(4);
    load <= 8'h00;
    cyc(600 * TDIV);
    chk("restart", 32'(wa_s), 32'h0000_0001);
    cyc(420 * TDIV);
    chk("autoclr", 32'(wa_s), 32'h0000_0000);
    // battery follows the encoder latch even in latch mode
    wr(OFS_CTRL, 32'h0000_0001);
    batt <= 1'b1;
    cyc(6);
    rd(OFS_WARN_STAT);
    chk("batt_on", rd_v, 32'h0000_0008);
    batt <= 1'b0;
    cyc(6);
    rd(OFS_WARN_STAT);
    chk("batt_off", rd_v, 32'h0000_0000);
    // mains loss just below and above the detection time
    wr(OFS_MAINS_TIME, 32'h0000_000A);
    mains <= 1'b1;
    cyc(8 * TDIV);
    rd(OFS_NET_STAT);
    chk("mains_early", rd_v, 32'h0000_0000);
    cyc(6 * TDIV);
    rd(OFS_NET_STAT);
    chk("mains_flag", rd_v, 32'h0000_0001);
    rd(OFS_WARN_STAT);
    chk("mains_warn", rd_v, 32'h0000_4000);
    wr(OFS_MAINS_TIME, 32'h0000_07D0);
    clear_pulse();
    cyc(40 * TDIV);
    rd(OFS_WARN_STAT);
    chk("mains_off", rd_v, 32'h0000_0000);
    wr(OFS_MAINS_TIME, 32'h0000_0009);
    cyc(4);
    rd(OFS_WARN_STAT);
    chk("mains_low", rd_v, 32'h0000_0000);
    mains <= 1'b0;
    // fan stopped: nothing before one second, warning after
    fan <= 1'b1;
    cyc(990 * TDIV);
    rd(OFS_WARN_STAT);
    chk("fan_early", rd_v, 32'h0000_0000);
    cyc(20 * TDIV);
    rd(OFS_WARN_STAT);
    chk("fan_warn", rd_v, 32'h0000_0010);
    fan <= 1'b0;
    clear_pulse();
    // frozen clock enable: a passing cause is never taken
    clk_en <= 1'b0;
    load <= 8'h55;
    cyc(8);
    {clk_en, load} <= {1'b1, 8'h00};
    rd(OFS_WARN_STAT);
    chk("frozen", rd_v, 32'h0000_0000);
    // reset in mid-run brings settings back to their reset values
    wr(OFS_OUT_SEL, 32'h0000_0101);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    rd(OFS_OUT_SEL);
    chk("reset_sel", rd_v, 32'h0000_0000);
    rd(OFS_CTRL);
    chk("reset_ctrl", rd_v, 32'h0000_0000);
    chk("reset_out_a", 32'(wa_s), 32'h0000_0000);
    stop_test();
  end
endmodule : servo_warning_manager_tb
